// ===== core/trailer_consts.svh
// constants for the readout trailer builder
`ifndef TRAILER_CONSTS_SVH
`define TRAILER_CONSTS_SVH
// ----------------------------------------
// trailer layout
// ----------------------------------------
`define TRL_WORDS 7'h09
`define TRL_LAST_IDX 4'h8
`define WID_MID 2'b10
`define WID_LAST 2'b11
`define ERR_HI 19
`define ERR_LO 7
`define PHASE_W 5
// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFF_ACT_A 12'h000
`define OFF_ACT_B 12'h004
`define OFF_DP1 12'h008
`define OFF_DP2 12'h00c
`define OFF_LOC 12'h010
`define OFF_CNT 12'h014
`define OFF_PAY 12'h018
`endif

// ===== core/trailer_pkg.sv
// types for the readout trailer builder
package trailer_pkg;
  typedef enum logic [0:0] {
    S_PAY = 1'b0,
    S_TRL = 1'b1
  } trl_state_e;

  typedef struct packed {
    logic valid;
    logic last;
    logic [31:0] data;
  } word_s;

  typedef struct packed {
    logic [19:0] err_a;
    logic [19:0] err_b;
    logic receive_ready_error;
    logic sparse_scan_length_error;
    logic [4:0] sparse_event_length_readout_error;
  } err_in_s;

  typedef struct packed {
    logic addr_stb;
    logic [11:0] addr;
    logic data_stb;
    logic trl_stb;
    logic [11:0] trl_chan;
    logic [9:0] trl_words;
  } chip_s;
endpackage : trailer_pkg

// ===== core/readout_trailer_builder.sv
// event payload pass-through with nine-word trailer
`timescale 1ns/10ps
`include "trailer_consts.svh"
module readout_trailer_builder #(
  parameter logic [9:0] FW_VERSION = 10'h015, // arbitrary value
  parameter int TRL_LEN = 9
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // payload in
  input wire trailer_pkg::word_s pay_in,
  output logic pay_ready,
  // to link interface unit
  output trailer_pkg::word_s link_out,
  // error and chip trailer events
  input wire trailer_pkg::err_in_s err_in,
  input wire trailer_pkg::chip_s chip
);
  import trailer_pkg::*;

  initial begin
    if (TRL_LEN != 9) begin
      $error("trailer length must be nine");
    end
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    trl_state_e st;
    logic [3:0] idx;
    logic [25:0] pay_cnt;
    logic [11:0] ch_err;
    logic [12:0] bl_err;
    logic [9:0] stb_cnt;
    logic [11:0] last_ch;
    logic [25:0] act_a;
    logic [25:0] act_b;
    logic [25:0] dp1;
    logic [25:0] dp2;
    logic [8:0] loc;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    word_s out;
    logic pay_rdy;
  } state_s;

  state_s cur_ff;
  state_s nxt_cur;

  // ----------------------------------------
  // trailer value select
  // ----------------------------------------
  function automatic logic [25:0] trl_value(
    input state_s s,
    input err_in_s e
  );
    logic [25:0] v;
    v = 26'h0;
    case (s.idx)
      4'h0: begin
        v = s.pay_cnt;
      end
      4'h1: begin
        // bits 19..7 carry fault flags
        v = {e.err_a[`ERR_HI:`ERR_LO],
             e.err_b[`ERR_HI:`ERR_LO]};
      end
      4'h2: begin
        v = {17'h0,
             s.bl_err != 13'h0,
             s.ch_err != 12'h0,
             e.receive_ready_error,
             e.sparse_scan_length_error,
             e.sparse_event_length_readout_error};
      end
      4'h3: begin
        v = {1'b0, s.bl_err, s.ch_err};
      end
      4'h4: begin
        v = s.act_a;
      end
      4'h5: begin
        v = s.act_b;
      end
      4'h6: begin
        v = s.dp1;
      end
      4'h7: begin
        // low bits hold sampling phase
        v = s.dp2;
      end
      4'h8: begin
        // side, sector, partition in loc
        v = {FW_VERSION, s.loc, `TRL_WORDS};
      end
      default: begin
        v = 26'h0;
      end
    endcase
    return v;
  endfunction : trl_value

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic acc;
    logic [1:0] wid;
    acc = 1'b0;
    wid = `WID_MID;
    nxt_cur = cur_ff;
    nxt_cur.out.valid = 1'b0;
    nxt_cur.out.last = 1'b0;

    // apb: one wait state, commit when pready seen
    acc = psel && penable;
    if (acc && cur_ff.pready) begin
      nxt_cur.pready = 1'b0;
      nxt_cur.pslverr = 1'b0;
      if (pwrite) begin
        case (paddr)
          `OFF_ACT_A: begin
            nxt_cur.act_a = pwdata[25:0];
          end
          `OFF_ACT_B: begin
            nxt_cur.act_b = pwdata[25:0];
          end
          `OFF_DP1: begin
            nxt_cur.dp1 = pwdata[25:0];
          end
          `OFF_DP2: begin
            nxt_cur.dp2 = pwdata[25:0];
          end
          `OFF_LOC: begin
            nxt_cur.loc = pwdata[8:0];
          end
          default: begin
          end
        endcase
      end
    end else if (acc) begin
      nxt_cur.pready = 1'b1;
      nxt_cur.pslverr = 1'b0;
      nxt_cur.prdata = 32'h0;
      case (paddr)
        `OFF_ACT_A: begin
          nxt_cur.prdata = {6'h0, cur_ff.act_a};
        end
        `OFF_ACT_B: begin
          nxt_cur.prdata = {6'h0, cur_ff.act_b};
        end
        `OFF_DP1: begin
          nxt_cur.prdata = {6'h0, cur_ff.dp1};
        end
        `OFF_DP2: begin
          nxt_cur.prdata = {6'h0, cur_ff.dp2};
        end
        `OFF_LOC: begin
          nxt_cur.prdata = {23'h0, cur_ff.loc};
        end
        `OFF_CNT: begin
          nxt_cur.prdata = {7'h0, cur_ff.bl_err,
                            cur_ff.ch_err};
        end
        `OFF_PAY: begin
          nxt_cur.prdata = {6'h0, cur_ff.pay_cnt};
        end
        default: begin
          nxt_cur.pslverr = 1'b1;
        end
      endcase
    end else begin
      nxt_cur.pready = 1'b0;
      nxt_cur.pslverr = 1'b0;
    end

    // chip trailer checks
    if (chip.addr_stb) begin
      nxt_cur.last_ch = chip.addr;
      nxt_cur.stb_cnt = 10'h0;
    end else if (chip.data_stb) begin
      nxt_cur.stb_cnt = cur_ff.stb_cnt + 10'h1;
    end
    if (chip.trl_stb) begin
      if (chip.trl_chan != cur_ff.last_ch) begin
        nxt_cur.ch_err = cur_ff.ch_err + 12'h1;
      end
      if (chip.trl_words != cur_ff.stb_cnt) begin
        nxt_cur.bl_err = cur_ff.bl_err + 13'h1;
      end
    end

    // ----------------------------------------
    // stream
    // ----------------------------------------
    case (cur_ff.st)
      S_PAY: begin
        if (pay_in.valid && cur_ff.pay_rdy) begin
          nxt_cur.out.valid = 1'b1;
          nxt_cur.out.data = pay_in.data;
          nxt_cur.pay_cnt = cur_ff.pay_cnt + 26'h1;
          if (pay_in.last) begin
            nxt_cur.st = S_TRL;
            nxt_cur.idx = 4'h0;
            nxt_cur.pay_rdy = 1'b0;
          end
        end
      end
      S_TRL: begin
        if (cur_ff.idx == `TRL_LAST_IDX) begin
          wid = `WID_LAST;
        end else begin
          wid = `WID_MID;
        end
        nxt_cur.out.valid = 1'b1;
        // identifier, code, value
        nxt_cur.out.data = {wid, cur_ff.idx,
                            trl_value(cur_ff, err_in)};
        nxt_cur.idx = cur_ff.idx + 4'h1;
        if (cur_ff.idx == `TRL_LAST_IDX) begin
          nxt_cur.out.last = 1'b1;
          nxt_cur.st = S_PAY;
          nxt_cur.pay_rdy = 1'b1;
          nxt_cur.pay_cnt = 26'h0;
          nxt_cur.ch_err = 12'h0;
          nxt_cur.bl_err = 13'h0;
        end
      end
      default: begin
        nxt_cur.st = S_PAY;
        nxt_cur.pay_rdy = 1'b1;
      end
    endcase
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_ff <= '0;
      cur_ff.pay_rdy <= 1'b1;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign prdata = cur_ff.prdata;
  assign pready = cur_ff.pready;
  assign pslverr = cur_ff.pslverr;
  assign pay_ready = cur_ff.pay_rdy;
  assign link_out = cur_ff.out;

endmodule : readout_trailer_builder

// ===== test/readout_trailer_chk.sv
// assertion checker for the readout trailer builder
`timescale 1ns/10ps
module readout_trailer_chk #(parameter int TRL_LEN = 9) (
  // clock, reset, apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // stream
  input wire trailer_pkg::word_s pay_in,
  input wire logic pay_ready,
  input wire trailer_pkg::word_s link_out
);
  import trailer_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic tl = pay_in.valid && pay_ready && pay_in.last;
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready too long");
  one_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("no answer");
  unmapped_err_a: assert property (psel && penable && pready && paddr > 12'h018 |-> pslverr)
    else $error("no slave error");
  pass_word_a: assert property (pay_in.valid && pay_ready |=>
    link_out.valid && link_out.data == $past(pay_in.data)) else $error("payload lost");
  first_word_a: assert property (tl |-> ##2 link_out.data[31:26] == 6'b100000)
    else $error("bad first word");
  trl_hold_a: assert property (tl |=> !pay_ready [*8] ##1 !pay_ready ##1 pay_ready)
    else $error("ready wrong");
  last_time_a: assert property (tl |-> ##10 link_out.valid && link_out.last)
    else $error("last late");
  last_form_a: assert property (link_out.last |-> link_out.data[31:26] == 6'b111000 &&
    link_out.data[6:0] == 7'(TRL_LEN)) else $error("bad last word");
  code_order_a: assert property (link_out.last |-> $past(link_out.valid) &&
    $past(link_out.data[29:26]) == 4'h7) else $error("order wrong");
endmodule : readout_trailer_chk
bind readout_trailer_builder readout_trailer_chk #(.TRL_LEN(TRL_LEN)) chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
  .pslverr(pslverr), .pay_in(pay_in), .pay_ready(pay_ready), .link_out(link_out));

// ===== test/link_sink_model.sv
// link interface unit model that records every link word
`timescale 1ns/10ps
module link_sink_model (
  // clock and link
  input wire logic pclk,
  input wire trailer_pkg::word_s link_out
);
  import trailer_pkg::*;
  logic [32:0] rx_q [$];
  always @(posedge pclk) begin
    if (link_out.valid === 1'b1) begin
      rx_q.push_back({link_out.last, link_out.data});
    end
  end
endmodule : link_sink_model

// ===== test/tb_top.sv
// self-checking bench for the readout trailer builder
`timescale 1ns/10ps
module tb_top;
  import trailer_pkg::*;
  localparam logic [9:0] FW = 10'h2a5; // arbitrary value
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, re;
  logic pay_ready;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, rt, rs = 32'he7db, cfg [5];
  word_s pay_in = '0, link_out;
  err_in_s err_in = '0;
  chip_s chip = '0;
  int errors = 0, checked = 0;
  always #2.5 pclk = ~pclk;
  readout_trailer_builder #(.FW_VERSION(FW)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pay_in(pay_in), .pay_ready(pay_ready),
    .link_out(link_out), .err_in(err_in), .chip(chip));
  link_sink_model sink (.pclk(pclk), .link_out(link_out));
  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction : xs
  function automatic logic [31:0] exp_trl(input int c, input int n, input int b);
    logic [25:0] v;
    case (c)
      0: v = 26'(n);
      1: v = {err_in.err_a[19:7], err_in.err_b[19:7]};
      2: v = {17'h0, b != 0, b != 0, err_in[6:0]};
      3: v = 26'(b * 32'h1001);
      8: v = {FW, cfg[4][8:0], 7'h09};
      default: v = cfg[c - 4][25:0];
    endcase
    return {1'b1, c == 8, 4'(c), v};
  endfunction : exp_trl
  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    t = 0;
    do begin
      @(posedge pclk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    rd = prdata;
    re = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask : apb
  task automatic chip_evt(input logic [11:0] a, input int k, input logic bad);
    chip <= '{1'b1, a, 1'b0, 1'b0, 12'h0, 10'h0};
    @(posedge pclk);
    repeat (k) begin
      chip <= '{1'b0, a, 1'b1, 1'b0, 12'h0, 10'h0};
      @(posedge pclk);
      chip <= '0;
      @(posedge pclk);
    end
    chip <= '{1'b0, a, 1'b0, 1'b1, a ^ {11'h0, bad}, 10'(k + bad)};
    @(posedge pclk);
    chip <= '0;
    @(posedge pclk);
  endtask : chip_evt
  task automatic run_event(input int n, input int b);
    logic [31:0] pw [$];
    int t;
    for (int i = 0; i < 2; i++) begin
      rt = xs();
      chip_evt(rt[11:0], 1 + rt[13:12], i < b);
    end
    err_in <= 47'({xs(), xs()});
    apb(1, 12'h014, xs());
    apb(0, 12'h014, 0);
    cmp({re, rd}, {1'b0, 32'(b * 32'h1001)});
    sink.rx_q.delete();
    for (int i = 0; i < n; i++) begin
      rt = xs();
      pw.push_back(rt);
      pay_in <= '{1'b1, i == n - 1, rt};
      @(posedge pclk);
    end
    pay_in <= '0;
    t = 0;
    while (sink.rx_q.size() < n + 9 && t < 100) begin
      @(posedge pclk);
      t++;
    end
    for (int i = 0; i < n; i++) cmp(sink.rx_q[i], {1'b0, pw[i]});
    for (int c = 0; c < 9; c++) begin
      if (c < 4) cmp(sink.rx_q[n + c], {1'b0, exp_trl(c, n, b)});
      else cmp(sink.rx_q[n + c], {c == 8, exp_trl(c, n, b)});
    end
  endtask : run_event
  task automatic final_report();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    for (int i = 0; i < 5; i++) begin
      rt = xs();
      cfg[i] = i == 4 ? {23'h0, rt[8], 5'(rt[7:3] % 18), 3'(rt[2:0] % 6)} : {6'h0, rt[25:0]};
      apb(1, 12'(4 * i), cfg[i]);
      apb(0, 12'(4 * i), 0);
      cmp({re, rd}, {1'b0, cfg[i]});
    end
    apb(0, 12'h01c, 0);
    cmp({32'h0, re}, {32'h0, 1'b1});
    run_event(1, 2);
    run_event(4, 0);
    run_event(2, 1);
    final_report();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    final_report();
  end
endmodule : tb_top
